// ---- srb_cfg.svh ----
// register offsets, field positions, reset values and sampling counts
// assumes inclusion by the receiver module and the testbench
`ifndef SRB_CFG_SVH
`define SRB_CFG_SVH

`define SRB_OFS_DATA 12'h000
`define SRB_OFS_STAT 12'h004
`define SRB_OFS_CTLB 12'h008
`define SRB_OFS_CTLC 12'h00C
`define SRB_OFS_BAUD 12'h010

// status register
`define SRB_ST_RXC 7
`define SRB_ST_FE 4
`define SRB_ST_DOR 3
`define SRB_ST_PE 2
// control register b
`define SRB_CB_IE 7
`define SRB_CB_EN 4
`define SRB_CB_SZ2 2
`define SRB_CB_RB8 1
// control register c
`define SRB_CC_SYNC 6
`define SRB_CC_PEN 5
`define SRB_CC_PODD 4
`define SRB_CC_STOP2 3
`define SRB_CC_SZ_LO 1

`define SRB_CTLB_RST 8'h00
`define SRB_CTLC_RST 8'h06
`define SRB_BAUD_RST 16'h0043
`define SRB_SZ_NINE 3'h7

`define SRB_SMP_LAST 5'h10
`define SRB_SMP_V1 5'h08
`define SRB_SMP_V2 5'h09
`define SRB_SMP_V3 5'h0A

`endif

// ---- srb_pkg.sv ----
// types shared by the serial receive buffer
// assumes srb_cfg.svh defines the numbers
package srb_pkg;
  typedef enum logic [2:0] {
    SRB_IDLE,
    SRB_START,
    SRB_DATA,
    SRB_PARITY,
    SRB_STOP
  } srb_state_t;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic overrun_flag;
    logic pe;
  } srb_entry_t;
endpackage

// ---- srb_rx_top.sv ----
// receive half of a serial port: start detect, shifter, two-entry fifo
// assumes an apb master on clock_i and a remote transmitter on rxd_i
//
// Operation
// - setting receiver enable makes the receive pin the serial input
// - synchronous mode clocks bits from the transfer clock pin
// - after a valid start bit, sample and shift bits until first stop
// - a second stop bit is never examined
// - on first stop bit the shifter moves into the receive buffer
// - unused upper data bits read as zero for short frames
// - each data read advances the fifo, changing ninth bit and flags
// - receive complete reads one exactly while unread data exist
// - clearing receiver enable flushes the buffer, complete flag drops
// - interrupt requested while complete flag, enable and global enable
// - error flags are stored with their frame in the fifo
// - writes to the status register never change error flags
// - error flags never raise an interrupt
// - frame error equals inverted first stop bit, stop count ignored
// - overrun when fifo full, frame waiting and new start detected
// - overrun clears on the next successful move into the fifo
// - parity checked over data bits, odd or even, result stored
// - parity error reads zero when checking is disabled
// - disabling the receiver is immediate and drops a frame in flight
// - asynchronous start valid only if two of samples 8, 9, 10 are low
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "srb_cfg.svh"

module srb_rx_top
  import srb_pkg::*;
#(
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial pins
  input wire logic rxd_i,
  input wire logic xck_i,
  output logic rx_pin_override_o,
  // interrupt
  input wire logic global_irq_enable_i,
  output logic irq_o
);

  // pin synchronisers
  logic rxd_s1, rxd_s2, xck_s1, xck_s2, xck_s3;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_s3 <= 1'b0;
    end else begin
      rxd_s1 <= rxd_i;
      rxd_s2 <= rxd_s1;
      xck_s1 <= xck_i;
      xck_s2 <= xck_s1;
      xck_s3 <= xck_s2;
    end
  end

  // control registers
  logic [7:0] ctlb, ctlc;
  logic [15:0] baud_div;
  logic rx_en, sync_mode, par_en, par_odd;
  logic [2:0] char_sz;
  assign rx_en = ctlb[`SRB_CB_EN];
  assign sync_mode = ctlc[`SRB_CC_SYNC];
  assign par_en = ctlc[`SRB_CC_PEN];
  assign par_odd = ctlc[`SRB_CC_PODD];
  assign char_sz = {ctlb[`SRB_CB_SZ2], ctlc[`SRB_CC_SZ_LO+1:`SRB_CC_SZ_LO]};

  // apb handshake: one wait state, then pready from a flop
  logic apb_done, wr_done, rd_done, pop;
  assign apb_done = psel_i & penable_i & pready_o;
  assign wr_done = apb_done & pwrite_i;
  assign rd_done = apb_done & ~pwrite_i;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctlb <= `SRB_CTLB_RST;
      ctlc <= `SRB_CTLC_RST;
      baud_div <= `SRB_BAUD_RST;
    end else if (wr_done) begin
      case (paddr_i)
        `SRB_OFS_CTLB: ctlb <= pwdata_i[7:0] & 8'hFC;
        `SRB_OFS_CTLC: ctlc <= pwdata_i[7:0];
        `SRB_OFS_BAUD: baud_div <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // baud divider: one-cycle tick at 16 times the bit rate
  logic [15:0] div_cnt;
  logic os_tick;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 16'h0000;
      os_tick <= 1'b0;
    end else if (!rx_en || div_cnt == baud_div) begin
      div_cnt <= 16'h0000;
      os_tick <= rx_en;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      os_tick <= 1'b0;
    end
  end

  // bit sampling and majority vote
  srb_state_t state;
  logic [4:0] smp;
  logic [1:0] votes;
  logic rx_prev, bit_stb, bit_val, xck_rise, maj;
  assign xck_rise = xck_s2 & ~xck_s3;
  assign maj = (votes[0] & votes[1]) | (votes[0] & rxd_s2)
    | (votes[1] & rxd_s2);
  always_comb begin
    if (sync_mode) begin
      bit_stb = xck_rise && state != SRB_IDLE;
      bit_val = rxd_s2;
    end else begin
      bit_stb = os_tick && state != SRB_IDLE && smp == `SRB_SMP_V3;
      bit_val = maj;
    end
  end

  logic start_det;
  assign start_det = rx_en && state == SRB_IDLE && (sync_mode
    ? (xck_rise && !rxd_s2) : (os_tick && rx_prev && !rxd_s2));

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp <= 5'h00;
      votes <= 2'b00;
      rx_prev <= 1'b1;
    end else if (!rx_en) begin
      smp <= 5'h00;
      votes <= 2'b00;
      rx_prev <= 1'b1;
    end else if (os_tick) begin
      rx_prev <= rxd_s2;
      if (start_det) begin
        smp <= 5'h01;
      end else if (state != SRB_IDLE) begin
        smp <= (smp == `SRB_SMP_LAST) ? 5'h01 : smp + 5'h01;
      end
      if (smp == `SRB_SMP_V1) begin
        votes[0] <= rxd_s2;
      end
      if (smp == `SRB_SMP_V2) begin
        votes[1] <= rxd_s2;
      end
    end
  end

  // frame state machine and shift register
  logic [8:0] shreg;
  logic [3:0] bit_cnt, nbits;
  logic par_acc, frame_done;
  srb_entry_t done_ent;
  assign nbits = (char_sz == `SRB_SZ_NINE) ? 4'd9
    : (char_sz[2] ? 4'd8 : {2'b01, char_sz[1:0]} + 4'd1);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SRB_IDLE;
      shreg <= 9'h000;
      bit_cnt <= 4'h0;
      par_acc <= 1'b0;
      frame_done <= 1'b0;
      done_ent <= '0;
    end else begin
      frame_done <= 1'b0;
      if (!rx_en) begin
        state <= SRB_IDLE;
        shreg <= 9'h000;
        bit_cnt <= 4'h0;
      end else if (start_det) begin
        state <= sync_mode ? SRB_DATA : SRB_START;
        shreg <= 9'h000;
        bit_cnt <= 4'h0;
        par_acc <= par_odd;
      end else if (bit_stb) begin
        case (state)
          SRB_START: begin
            state <= bit_val ? SRB_IDLE : SRB_DATA;
          end
          SRB_DATA: begin
            shreg[bit_cnt] <= bit_val;
            par_acc <= par_acc ^ bit_val;
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt + 4'h1 == nbits) begin
              state <= par_en ? SRB_PARITY : SRB_STOP;
            end
          end
          SRB_PARITY: begin
            par_acc <= par_acc ^ bit_val;
            state <= SRB_STOP;
          end
          SRB_STOP: begin
            // only the first stop bit is looked at
            state <= SRB_IDLE;
            frame_done <= 1'b1;
            done_ent.data <= shreg;
            done_ent.fe <= ~bit_val;
            done_ent.pe <= par_en & par_acc;
            done_ent.overrun_flag <= 1'b0;
          end
          default: state <= SRB_IDLE;
        endcase
      end
    end
  end

  // holding stage and two-entry fifo
  srb_entry_t fifo_mem [DEPTH];
  srb_entry_t hold, head;
  logic hold_full, push;
  logic [1:0] fifo_cnt;
  logic rd_ptr, wr_ptr;
  assign head = fifo_mem[rd_ptr];
  assign pop = rd_done && paddr_i == `SRB_OFS_DATA && fifo_cnt != 2'd0;
  assign push = hold_full && (fifo_cnt != 2'(DEPTH) || pop);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold <= '0;
      hold_full <= 1'b0;
    end else if (!rx_en) begin
      hold_full <= 1'b0;
    end else begin
      if (start_det && hold_full && fifo_cnt == 2'(DEPTH) && !pop) begin
        hold.overrun_flag <= 1'b1;
      end
      if (frame_done && (!hold_full || push)) begin
        hold <= done_ent;
        hold_full <= 1'b1;
      end else if (push) begin
        hold_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifo_cnt <= 2'd0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else if (!rx_en) begin
      fifo_cnt <= 2'd0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fifo_cnt <= fifo_cnt + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      fifo_mem[wr_ptr] <= hold;
    end
  end

  // read data and completion
  logic rxc;
  logic [31:0] next_rdata;
  logic addr_ok;
  assign rxc = fifo_cnt != 2'd0;
  always_comb begin
    next_rdata = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr_i)
      `SRB_OFS_DATA: next_rdata[7:0] = rxc ? head.data[7:0] : 8'h00;
      `SRB_OFS_STAT: begin
        next_rdata[`SRB_ST_RXC] = rxc;
        next_rdata[`SRB_ST_FE] = rxc & head.fe;
        next_rdata[`SRB_ST_DOR] = rxc & head.overrun_flag;
        next_rdata[`SRB_ST_PE] = rxc & head.pe & par_en;
      end
      `SRB_OFS_CTLB: begin
        next_rdata[7:0] = ctlb;
        next_rdata[`SRB_CB_RB8] = rxc & head.data[8];
      end
      `SRB_OFS_CTLC: next_rdata[7:0] = ctlc;
      `SRB_OFS_BAUD: next_rdata[15:0] = baud_div;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
      if (psel_i && penable_i && !pready_o) begin
        pslverr_o <= ~addr_ok;
        prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // pin override and interrupt, error flags play no part
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_pin_override_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      rx_pin_override_o <= rx_en;
      irq_o <= rxc & ctlb[`SRB_CB_IE] & global_irq_enable_i;
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_start_noise;
    state == SRB_START && !sync_mode && os_tick && smp == `SRB_SMP_V3
      && maj;
  endsequence

  a_start_reject: assert property (s_start_noise |=> state == SRB_IDLE)
    else $error("noisy start bit not rejected");
  a_disable_flush: assert property (!rx_en |=> fifo_cnt == 2'd0
      && state == SRB_IDLE && !hold_full)
    else $error("disable did not flush receiver");
  a_irq_level: assert property (rxc && ctlb[`SRB_CB_IE]
      && global_irq_enable_i ##1 rxc |-> irq_o)
    else $error("interrupt not requested with data pending");
  a_pop_advance: assert property (pop && !push |=> fifo_cnt
      == $past(fifo_cnt) - 2'd1)
    else $error("data read did not advance fifo");
  a_overrun_mark: assert property (start_det && hold_full && rx_en
      && fifo_cnt == 2'd2 && !pop && !frame_done |=> hold.overrun_flag)
    else $error("overrun not recorded");
  a_fe_capture: assert property (bit_stb && state == SRB_STOP && rx_en
      && !start_det |=> frame_done && done_ent.fe == !$past(bit_val))
    else $error("frame error does not match stop bit");
  a_pe_off: assert property (!par_en && paddr_i == `SRB_OFS_STAT
      |-> !next_rdata[`SRB_ST_PE])
    else $error("parity error visible while checking disabled");
  a_stat_write: assert property (wr_done && paddr_i == `SRB_OFS_STAT
      && !push && !pop |=> $stable(fifo_cnt) && $stable(rd_ptr))
    else $error("status write disturbed fifo");
  a_apb_wait: assert property (psel_i && penable_i && !pready_o
      |=> pready_o)
    else $error("apb access not answered");

endmodule // srb_rx_top

// ---- srb_tx_model.sv ----
// remote serial transmitter driving the receive pin of the receiver
// assumes one clock; a bit lasts BIT_CLKS clocks (baud divisor 0)
`timescale 1ns/100ps

module srb_tx_model #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input wire logic clock_i,
  // serial pins
  output logic rxd_o,
  output logic xck_o
);
  // line idles high; sync clock pin rests low outside synchronous frames
  initial begin
    rxd_o = 1'b1;
    xck_o = 1'b0;
  end

  task automatic bit_out(input logic b);
    @(posedge clock_i);
    rxd_o <= b;
    repeat (BIT_CLKS - 1) @(posedge clock_i);
  endtask

  // start, data lsb first, optional parity, one stop, then an idle bit
  task automatic send(input logic [8:0] d, input int nb, input logic pen,
      input logic par, input logic stop);
    bit_out(1'b0);
    for (int i = 0; i < nb; i++) begin
      bit_out(d[i]);
    end
    if (pen) begin
      bit_out(par);
    end
    bit_out(stop);
    bit_out(1'b1);
  endtask

  // synchronous frame of 8 data bits; data settles before each clock rise
  task automatic send_sync(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock_i);
      rxd_o <= f[i];
      repeat (4) @(posedge clock_i);
      xck_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      xck_o <= 1'b0;
    end
    repeat (8) @(posedge clock_i);
  endtask

  // low pulse far shorter than half a bit, then idle longer than a frame
  task automatic glitch();
    @(posedge clock_i);
    rxd_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    rxd_o <= 1'b1;
    repeat (12 * BIT_CLKS) @(posedge clock_i);
  endtask
endmodule // srb_tx_model

// ---- testbench.sv ----
// self-checking bench for the serial receive buffer
// assumes srb_rx_top, srb_tx_model and the offsets in srb_cfg.svh
`timescale 1ns/100ps
`include "srb_cfg.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end

module testbench;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic global_irq_enable_i = 1'b0;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic pready_o, pslverr_o, slv, rxd_i, xck_i, rx_pin_override_o, irq_o;
  int err_count = 0;
  int checks = 0;

  always #4 clock_i = ~clock_i;

  srb_rx_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rxd_i(rxd_i), .xck_i(xck_i),
    .rx_pin_override_o(rx_pin_override_o),
    .global_irq_enable_i(global_irq_enable_i), .irq_o(irq_o));

  srb_tx_model tx (.clock_i(clock_i), .rxd_o(rxd_i), .xck_o(xck_i));

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    slv = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    `CHK("pready", 1'b1, pready_o)
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string n, input logic [11:0] a,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(n, e, rd)
  endtask

  // frame then poll status for receive complete, bounded
  task automatic frame(input logic [8:0] d, input int nb, input logic pen,
      input logic pflip, input logic stop);
    int n;
    n = 0;
    tx.send(d, nb, pen, (^d) ^ pflip, stop);
    do begin
      apb(1'b0, `SRB_OFS_STAT, 32'h0000_0000);
      n++;
    end while (rd[`SRB_ST_RXC] !== 1'b1 && n < 100);
    `CHK("rxc", 1'b1, rd[`SRB_ST_RXC])
  endtask

  task automatic endt(input string n);
    $display("test %s done", n);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock_i);
    err_count++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rdc("ctlb", `SRB_OFS_CTLB, 32'h0000_0000);
    rdc("ctlc", `SRB_OFS_CTLC, 32'h0000_0006);
    rdc("baud", `SRB_OFS_BAUD, 32'h0000_0043);
    rdc("unmapped", 12'h020, 32'h0000_0000);
    `CHK("slverr", 1'b1, slv)
    endt("reset");
    wr(`SRB_OFS_BAUD, 32'h0000_0000);
    wr(`SRB_OFS_CTLB, 32'h0000_0010);
    repeat (2) @(posedge clock_i);
    `CHK("override", 1'b1, rx_pin_override_o)
    for (int s = 0; s < 4; s++) begin
      wr(`SRB_OFS_CTLC, 32'(s << 1));
      frame(9'h1FF, s + 5, 1'b0, 1'b0, 1'b1);
      rdc("short", `SRB_OFS_DATA, (32'h1 << (s + 5)) - 1);
      rdc("stat", `SRB_OFS_STAT, 32'h0000_0000);
    end
    endt("sizes");
    wr(`SRB_OFS_CTLC, 32'h0000_0006);
    wr(`SRB_OFS_CTLB, 32'h0000_0014);
    frame(9'h1A5, 9, 1'b0, 1'b0, 1'b1);
    frame(9'h05A, 9, 1'b0, 1'b0, 1'b1);
    rdc("ninth", `SRB_OFS_CTLB, 32'h0000_0016);
    rdc("d9a", `SRB_OFS_DATA, 32'h0000_00A5);
    rdc("ninth", `SRB_OFS_CTLB, 32'h0000_0014);
    rdc("d9b", `SRB_OFS_DATA, 32'h0000_005A);
    endt("nine");
    wr(`SRB_OFS_CTLB, 32'h0000_0010);
    wr(`SRB_OFS_CTLC, 32'h0000_000E);
    frame(9'h03C, 8, 1'b0, 1'b0, 1'b0);
    frame(9'h0C3, 8, 1'b0, 1'b0, 1'b1);
    rdc("fe", `SRB_OFS_STAT, 32'h0000_0090);
    wr(`SRB_OFS_STAT, 32'h0000_0000);
    rdc("fe", `SRB_OFS_STAT, 32'h0000_0090);
    rdc("dfe", `SRB_OFS_DATA, 32'h0000_003C);
    rdc("fe0", `SRB_OFS_STAT, 32'h0000_0080);
    rdc("dok", `SRB_OFS_DATA, 32'h0000_00C3);
    endt("frame error");
    for (int o = 0; o < 2; o++) begin
      wr(`SRB_OFS_CTLC, 32'h0000_0026 | 32'(o << 4));
      frame(9'h096, 8, 1'b1, 1'(o), 1'b1);
      frame(9'h096, 8, 1'b1, 1'(1 - o), 1'b1);
      rdc("pe0", `SRB_OFS_STAT, 32'h0000_0080);
      rdc("dp", `SRB_OFS_DATA, 32'h0000_0096);
      rdc("pe1", `SRB_OFS_STAT, 32'h0000_0084);
      rdc("dp", `SRB_OFS_DATA, 32'h0000_0096);
    end
    frame(9'h096, 8, 1'b1, 1'b0, 1'b1);
    wr(`SRB_OFS_CTLC, 32'h0000_0006);
    rdc("peoff", `SRB_OFS_STAT, 32'h0000_0080);
    rdc("dp", `SRB_OFS_DATA, 32'h0000_0096);
    endt("parity");
    tx.glitch();
    rdc("glitch", `SRB_OFS_STAT, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      frame(9'(8'h10 + i), 8, 1'b0, 1'b0, 1'b1);
    end
    rdc("ov0", `SRB_OFS_STAT, 32'h0000_0080);
    rdc("d0", `SRB_OFS_DATA, 32'h0000_0010);
    rdc("ov1", `SRB_OFS_STAT, 32'h0000_0080);
    rdc("d1", `SRB_OFS_DATA, 32'h0000_0011);
    rdc("ov2", `SRB_OFS_STAT, 32'h0000_0088);
    rdc("d2", `SRB_OFS_DATA, 32'h0000_0012);
    rdc("lost", `SRB_OFS_STAT, 32'h0000_0000);
    frame(9'h020, 8, 1'b0, 1'b0, 1'b1);
    rdc("ovclr", `SRB_OFS_STAT, 32'h0000_0080);
    rdc("d3", `SRB_OFS_DATA, 32'h0000_0020);
    endt("overrun");
    wr(`SRB_OFS_CTLB, 32'h0000_0090);
    @(posedge clock_i);
    global_irq_enable_i <= 1'b1;
    frame(9'h055, 8, 1'b0, 1'b0, 1'b1);
    `CHK("irq", 1'b1, irq_o)
    @(posedge clock_i);
    global_irq_enable_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    `CHK("irqgie", 1'b0, irq_o)
    global_irq_enable_i <= 1'b1;
    rdc("di", `SRB_OFS_DATA, 32'h0000_0055);
    repeat (2) @(posedge clock_i);
    `CHK("irqclr", 1'b0, irq_o)
    endt("interrupt");
    wr(`SRB_OFS_CTLB, 32'h0000_0010);
    frame(9'h033, 8, 1'b0, 1'b0, 1'b1);
    wr(`SRB_OFS_CTLB, 32'h0000_0000);
    rdc("flush", `SRB_OFS_STAT, 32'h0000_0000);
    `CHK("override", 1'b0, rx_pin_override_o)
    wr(`SRB_OFS_CTLB, 32'h0000_0010);
    fork
      tx.send(9'h0FF, 8, 1'b0, 1'b0, 1'b1);
      begin
        repeat (40) @(posedge clock_i);
        wr(`SRB_OFS_CTLB, 32'h0000_0000);
        wr(`SRB_OFS_CTLB, 32'h0000_0010);
      end
    join
    frame(9'h03C, 8, 1'b0, 1'b0, 1'b1);
    rdc("fresh", `SRB_OFS_DATA, 32'h0000_003C);
    rdc("dropped", `SRB_OFS_STAT, 32'h0000_0000);
    endt("disable");
    wr(`SRB_OFS_CTLC, 32'h0000_0046);
    tx.send_sync(8'hC9);
    rdc("sync", `SRB_OFS_STAT, 32'h0000_0080);
    rdc("syncd", `SRB_OFS_DATA, 32'h0000_00C9);
    wr(`SRB_OFS_CTLC, 32'h0000_0006);
    endt("sync");
    test_done();
  end
endmodule // testbench
